// ===== logic/prs_map.vh
`ifndef PRS_MAP_VH
`define PRS_MAP_VH
// Register byte addresses on the APB.
`define PRS_A_KEY      12'h000
`define PRS_A_DATA     12'h004
`define PRS_A_DIR      12'h008
`define PRS_A_FSEL     12'h00C
`define PRS_A_WAKE_EN  12'h010
`define PRS_A_READ     12'h014
`define PRS_A_BITOP    12'h018
`define PRS_A_ADCH     12'h01C
`define PRS_A_STAT     12'h020
`define PRS_A_MASK     12'h024
`define PRS_A_SLEEP    12'h028
// Reset values and the readback unlock key.
`define PRS_KEY_RST    8'h00
`define PRS_DATA_RST   8'hFF
`define PRS_DIR_RST    8'hFF
`define PRS_FSEL_RST   16'h0000
`define PRS_UNLOCK     8'hCA
// Pin function codes, two bits per pin.
`define PRS_FN_GPIO    2'h0
`define PRS_FN_PERIPH  2'h1
`define PRS_FN_ANALOG  2'h2
// Status bit positions.
`define PRS_ST_WAKE    0
`define PRS_ST_BITOP   1
// Bit operation field positions.
`define PRS_BO_SET     3
`define PRS_BO_REG     4
`endif

// ===== logic/prs_sync.v
`timescale 1ns/10ps
`default_nettype none
module prs_sync #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         nrst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= {W{1'b1}};
			s2_q <= {W{1'b1}};
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule // prs_sync
`default_nettype wire

// ===== logic/prs_wake.v
`timescale 1ns/10ps
`default_nettype none
module prs_wake #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         nrst,
	input  wire [W-1:0] pin_sync,
	input  wire [W-1:0] wake_en,
	input  wire         asleep,
	output wire         wake
);
	reg  [W-1:0] prev_q;
	wire [W-1:0] fall;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= {W{1'b1}};
		end else begin
			prev_q <= pin_sync;
		end
	end

	// Each pin has its own enable, so any mix of pins may wake the part.
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_fall
			assign fall[i] = prev_q[i] & ~pin_sync[i] & wake_en[i];
		end
	endgenerate
	assign wake = asleep & (|fall);
endmodule // prs_wake
`default_nettype wire

// ===== logic/prs_port.v
// How it works
// - Readback enable high only when key equals unlock.
// - Other key values: read path by function and direction.
// - Readback on: reads return actual pin levels.
// - Readback changes read and analog paths only.
// - Readback off: pins follow selected function; the drivers here follow data latch and direction only, whatever the function.
// - Readback off, GPIO function: direction 0 latch, 1 pin.
// - Readback off: analog path only if selected.
// - Readback on: selected channel analog path forced.
// - Reset sets data and direction bits high.
// - Output switch without write drives high.
// - Bit set/clear reads, modifies, writes byte.
// - Sleep: falling edge on enabled pin wakes.
// - Wake enable chosen per pin individually.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "prs_map.vh"
module prs_port #(
	parameter W = 8
) (
	input  wire          clk,
	input  wire          nrst,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	input  wire [W-1:0]  pin_in,
	output reg  [W-1:0]  pin_out,
	output reg  [W-1:0]  pin_oe,
	output reg  [W-1:0]  analog_sw,
	output reg           readback_enable,
	output reg           wake_req,
	output reg           irq
);
	reg  [7:0]     readback_test_key_q;
	reg  [W-1:0]   port_data_q;
	reg  [W-1:0]   port_direction_q;
	reg  [2*W-1:0] fsel_q;
	reg  [W-1:0]   wake_en_q;
	reg  [2:0]     adc_chan_q;
	reg  [1:0]     stat_q;
	reg  [1:0]     mask_q;
	reg            sleep_q;
	reg  [W-1:0]   rd_val;
	reg  [W-1:0]   ana_d;
	reg  [W-1:0]   rmw;
	reg  [31:0]    rdata_d;
	reg            hit;
	wire [W-1:0]   pin_s;
	wire           wake;
	wire           key_ok;
	wire           acc;
	wire           wr;
	wire           rd;
	wire [2:0]     bo_bit;
	wire [1:0]     set_ev;
	wire [1:0]     clr_ev;
	integer        i;

	prs_sync #(.W(W)) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    (pin_in),
		.q    (pin_s)
	);

	prs_wake #(.W(W)) u_wake (
		.clk      (clk),
		.nrst     (nrst),
		.pin_sync (pin_s),
		.wake_en  (wake_en_q),
		.asleep   (sleep_q),
		.wake     (wake)
	);

	// The unlock compare is purely combinational on the stored key, so a key write
	// is visible to the very next port read.
	assign key_ok = (readback_test_key_q == `PRS_UNLOCK);
	assign acc    = psel & penable;
	assign wr     = acc & pwrite;
	assign rd     = acc & ~pwrite;
	assign bo_bit = pwdata[2:0];

	// Port read value per pin.
	always @* begin
		for (i = 0; i < W; i = i + 1) begin
			if (key_ok) begin
				rd_val[i] = pin_s[i];
			end else if (fsel_q[2*i +: 2] == `PRS_FN_ANALOG) begin
				rd_val[i] = port_direction_q[i];
			end else if (fsel_q[2*i +: 2] == `PRS_FN_PERIPH) begin
				rd_val[i] = pin_s[i];
			end else if (port_direction_q[i]) begin
				rd_val[i] = pin_s[i];
			end else begin
				rd_val[i] = port_data_q[i];
			end
		end
	end

	// Analog switch per pin; channel index equals pin index here.
	always @* begin
		for (i = 0; i < W; i = i + 1) begin
			if (key_ok) begin
				ana_d[i] = (adc_chan_q == i[2:0]) &
					((fsel_q[2*i +: 2] == `PRS_FN_ANALOG) | 1'b1);
			end else begin
				ana_d[i] = (adc_chan_q == i[2:0]) &
					(fsel_q[2*i +: 2] == `PRS_FN_ANALOG);
			end
		end
	end

	// A bit operation on the data latch reads the whole port first, so pins read as inputs may be
	// written back into the latch; this matches the documented read-modify-write.
	always @* begin
		if (pwdata[`PRS_BO_REG]) begin
			rmw = port_direction_q;
		end else begin
			rmw = rd_val;
		end
		rmw[bo_bit] = pwdata[`PRS_BO_SET];
	end

	assign set_ev[`PRS_ST_WAKE]  = wake;
	assign set_ev[`PRS_ST_BITOP] = wr & (paddr == `PRS_A_BITOP);
	assign clr_ev = (rd & (paddr == `PRS_A_STAT)) ? 2'h3 : 2'h0;

	always @* begin
		hit     = 1'b1;
		rdata_d = 32'h00000000;
		case (paddr)
			`PRS_A_KEY:     rdata_d[7:0]     = readback_test_key_q;
			`PRS_A_DATA:    rdata_d[W-1:0]   = port_data_q;
			`PRS_A_DIR:     rdata_d[W-1:0]   = port_direction_q;
			`PRS_A_FSEL:    rdata_d[2*W-1:0] = fsel_q;
			`PRS_A_WAKE_EN: rdata_d[W-1:0]   = wake_en_q;
			`PRS_A_READ:    rdata_d[W-1:0]   = rd_val;
			`PRS_A_BITOP:   rdata_d          = 32'h00000000;
			`PRS_A_ADCH:    rdata_d[2:0]     = adc_chan_q;
			`PRS_A_STAT:    rdata_d[1:0]     = stat_q;
			`PRS_A_MASK:    rdata_d[1:0]     = mask_q;
			`PRS_A_SLEEP:   rdata_d[0]       = sleep_q;
			default:        hit              = 1'b0;
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			readback_test_key_q <= `PRS_KEY_RST;
			port_data_q         <= {W{1'b1}};
			port_direction_q    <= {W{1'b1}};
			fsel_q              <= {2*W{1'b0}};
			wake_en_q           <= {W{1'b0}};
			adc_chan_q          <= 3'h0;
			stat_q              <= 2'h0;
			mask_q              <= 2'h0;
			sleep_q             <= 1'b0;
			prdata              <= 32'h00000000;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			pin_out             <= {W{1'b1}};
			pin_oe              <= {W{1'b0}};
			analog_sw           <= {W{1'b0}};
			readback_enable     <= 1'b0;
			wake_req            <= 1'b0;
			irq                 <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			if (psel & ~penable & ~pwrite) begin
				prdata <= rdata_d;
			end
			if (wr & pready) begin
				case (paddr)
					`PRS_A_KEY:     readback_test_key_q <= pwdata[7:0];
					`PRS_A_DATA:    port_data_q         <= pwdata[W-1:0];
					`PRS_A_DIR:     port_direction_q    <= pwdata[W-1:0];
					`PRS_A_FSEL:    fsel_q              <= pwdata[2*W-1:0];
					`PRS_A_WAKE_EN: wake_en_q           <= pwdata[W-1:0];
					`PRS_A_ADCH:    adc_chan_q          <= pwdata[2:0];
					`PRS_A_MASK:    mask_q              <= pwdata[1:0];
					`PRS_A_SLEEP:   sleep_q             <= pwdata[0];
					`PRS_A_BITOP: begin
						if (pwdata[`PRS_BO_REG]) begin
							port_direction_q <= rmw;
						end else begin
							port_data_q <= rmw;
						end
					end
					default: ;
				endcase
			end
			if (wake) begin
				sleep_q <= 1'b0;
			end
			// Set wins over the read clear so a wake in the read cycle survives.
			stat_q <= (stat_q & ~(clr_ev & {2{pready}})) | (set_ev & {2{~wr | pready}});
			irq    <= |(stat_q & mask_q);
			wake_req <= wake;
			// Drivers follow the data latch and direction register only; readback never touches them.
			pin_out   <= port_data_q;
			pin_oe    <= ~port_direction_q;
			analog_sw <= ana_d;
			readback_enable <= key_ok;
		end
	end
endmodule // prs_port
`default_nettype wire

// ===== tb/prs_pins.sv
`timescale 1ns/10ps
`default_nettype none
module prs_pins (
	input  wire  [7:0] pin_out,
	input  wire  [7:0] pin_oe,
	input  wire  [7:0] ext,
	input  wire  [7:0] stuck,
	output logic [7:0] pin_in
);
	// A stuck line beats the port's own driver, like a short to a stiff source.
	// This is what lets a read tell the latch apart from the pin.
	assign pin_in = (pin_oe & ~stuck & pin_out) | (~(pin_oe & ~stuck) & ext);
endmodule // prs_pins
`default_nettype wire

// ===== tb/prs_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module prs_port_chk #(parameter W = 8) (
	input wire         clk,
	input wire         nrst,
	input wire         psel,
	input wire         penable,
	input wire         pwrite,
	input wire [11:0]  paddr,
	input wire [31:0]  pwdata,
	input wire         pready,
	input wire         pslverr,
	input wire [W-1:0] pin_out,
	input wire [W-1:0] pin_oe,
	input wire         readback_enable,
	input wire         wake_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence acc_wr;
		psel && penable && pready && pwrite;
	endsequence
	property wr_data_p;
		logic [7:0] v;
		(acc_wr ##0 (paddr == 12'h004, v = pwdata[7:0])) |-> ##[1:2] pin_out == v;
	endproperty
	property bit_p(logic [1:0] op, logic lvl);
		logic [2:0] b;
		(acc_wr ##0 (paddr == 12'h018 && pwdata[4:3] == op, b = pwdata[2:0]))
			|-> ##[1:2] (op[1] ? pin_oe[b] : pin_out[b]) == lvl;
	endproperty
	ready_a: assert property (pready == (psel && penable)) else $error("pready off");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	unlock_on_a: assert property (acc_wr ##0 (paddr == 12'h000 && pwdata[7:0] == 8'hCA)
		|-> ##[1:2] readback_enable) else $error("unlock ignored");
	unlock_off_a: assert property (acc_wr ##0 (paddr == 12'h000 && pwdata[7:0] != 8'hCA)
		|-> ##[1:2] !readback_enable) else $error("lock ignored");
	reset_dflt_a: assert property ($rose(nrst) |-> &pin_out && pin_oe == 0)
		else $error("reset pins");
	wake_pulse_a: assert property (wake_req |=> !wake_req) else $error("wake stuck");
	latch_drive_a: assert property (wr_data_p) else $error("latch not driven");
	bit_set_a: assert property (bit_p(2'b01, 1'b1)) else $error("bit set lost");
	dir_clr_a: assert property (bit_p(2'b10, 1'b1)) else $error("dir clear lost");
endmodule // prs_port_chk
bind prs_port prs_port_chk #(.W(W)) chk_u (.*);
`default_nettype wire

// ===== tb/prs_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "prs_map.vh"
module prs_port_tb;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, rb, wake_req, irq, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  pin_in, pin_out, pin_oe, analog_sw, ext, stuck;
	int          err_count, check_count, wakes;
	prs_port dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_sw(analog_sw),
		.readback_enable(rb), .wake_req(wake_req), .irq(irq));
	prs_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .stuck(stuck),
		.pin_in(pin_in));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (wake_req === 1'b1) wakes <= wakes + 1;
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Outputs are judged at the falling edge, clear of every register update.
	task automatic settle;
		repeat (5) @(negedge clk);
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// The answer is taken at the rising edge where pready is seen high, never earlier.
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 1, 0);
		rd = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdchk(logic [11:0] a, logic [31:0] e, string n);
		apb(0, a, 0);
		chk(n, e, rd);
	endtask
	task automatic t_reset;
		chk("pin_out", 8'hFF, pin_out);
		chk("pin_oe", 8'h00, pin_oe);
		rdchk(`PRS_A_DATA, 32'hFF, "data");
		rdchk(`PRS_A_DIR, 32'hFF, "dir");
		rdchk(`PRS_A_KEY, 32'h00, "key");
		apb(1, 12'h030, 32'h1);
		chk("pslverr", 1, serr);
	endtask
	task automatic t_rb;
		apb(1, `PRS_A_ADCH, 32'h3);
		apb(1, `PRS_A_DIR, 32'h0F);
		settle;
		chk("pin_oe", 8'hF0, pin_oe);
		chk("pin_out", 8'hFF, pin_out);
		rdchk(`PRS_A_READ, 32'hFA, "read off");
		apb(1, `PRS_A_KEY, 32'hCA);
		settle;
		chk("rb on", 1, rb);
		chk("analog on", 8'h08, analog_sw);
		chk("pin_oe kept", 8'hF0, pin_oe);
		rdchk(`PRS_A_READ, 32'h5A, "read on");
		apb(1, `PRS_A_KEY, 32'hCB);
		settle;
		chk("rb off", 0, rb);
		chk("analog off", 8'h00, analog_sw);
		rdchk(`PRS_A_READ, 32'hFA, "read latch");
	endtask
	task automatic t_bit;
		apb(1, `PRS_A_BITOP, 32'h07);
		rdchk(`PRS_A_DATA, 32'h7A, "rmw clr");
		apb(1, `PRS_A_BITOP, 32'h10);
		rdchk(`PRS_A_DIR, 32'h0E, "dir clr");
		settle;
		apb(1, `PRS_A_BITOP, 32'h0F);
		rdchk(`PRS_A_DATA, 32'hFA, "rmw set");
	endtask
	task automatic t_wake;
		apb(0, `PRS_A_STAT, 0);
		apb(1, `PRS_A_WAKE_EN, 32'h08);
		apb(1, `PRS_A_MASK, 32'h01);
		apb(1, `PRS_A_SLEEP, 32'h01);
		ext <= 8'h58;
		settle;
		chk("no wake", 0, wakes);
		@(posedge clk);
		ext <= 8'h50;
		settle;
		chk("wake", 1, wakes);
		chk("irq", 1, irq);
		rdchk(`PRS_A_SLEEP, 32'h0, "sleep");
		apb(1, `PRS_A_MASK, 32'h0);
		settle;
		chk("irq masked", 0, irq);
		apb(1, `PRS_A_MASK, 32'h1);
		settle;
		chk("irq back", 1, irq);
		rdchk(`PRS_A_STAT, 32'h1, "stat");
		settle;
		chk("irq clr", 0, irq);
	endtask
	initial begin
		#200000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		nrst = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{err_count, check_count, wakes} = '0;
		ext = 8'h5A;
		stuck = 8'hF0;
		repeat (8) @(posedge clk);
		nrst <= 1;
		settle;
		t_reset;
		t_rb;
		t_bit;
		t_wake;
		tally_and_finish;
	end
endmodule // prs_port_tb
`default_nettype wire
